/* File: mcir_top.sv */
// configuration, status, mask and pin logic of the hardware monitor.
// assumes the serial interface runs on link_clk and presents decoded byte
// accesses; the conversion loop runs on sys_clk and reports per conversion.
`timescale 1ns/1ps
`default_nettype none
module mcir_top #(
	parameter int unsigned RST_PULSE_CYC = mcir_pkg::RST_PULSE_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic lnk_req,
	input wire mcir_pkg::mcir_req_t lnk_cmd,
	output logic lnk_busy,
	output logic lnk_ack,
	output logic [7:0] lnk_rdata,
	input wire logic conv_done,
	input wire logic [6:0] volt_out_of_limit,
	input wire logic [1:0] fan_over_limit,
	input wire logic [1:0] temp_above_limit,
	input wire logic [1:0] temp_below_hyst,
	input wire logic ext_int_in_n,
	input wire logic board_temp_alert_in_n,
	input wire logic intrusion_input_i,
	output logic intrusion_input_o,
	output logic intrusion_input_oe,
	output logic int_pin_o,
	output logic int_pin_oe,
	output logic reset_or_overtemp_pin_o,
	output logic reset_or_overtemp_pin_oe,
	output logic general_output_pin_o,
	output logic general_output_pin_oe,
	output logic monitor_run,
	output logic [7:0] fan_divisor,
	output logic [7:0] temp_config
);
	// ======================================================
	// declarations
	localparam int CW = $clog2(RST_PULSE_CYC + 1); // pulse counter width
	localparam logic [CW-1:0] PULSE_LAST = CW'(RST_PULSE_CYC - 1);

	logic sys_req; // one-cycle access strobe, core clock
	mcir_pkg::mcir_req_t cmd; // access being served
	logic [7:0] rdata; // read mux
	logic wr_en, rd_en; // decoded strobes
	logic [7:0] cfg_q; // configuration register
	logic [7:0] st1_q, st2_q; // status registers
	logic [7:0] msk1_q, msk2_q; // mask registers
	logic [7:0] fdiv_q, tcfg_q; // pin function and temp config
	logic init; // restore defaults this cycle
	logic active; // monitoring running
	logic [2:0] pins_s; // synchronised pin levels
	logic ext_low, board_low, intr_high; // pin events
	logic [1:0] temp_evt; // hot and shutdown events
	logic [1:0] temp_mode; // 1 selects one-time mode
	logic [1:0] hot_q; // above-limit state per sensor
	logic [7:0] st1_set, st2_set; // hardware sets this cycle
	logic rd_st1, rd_st2; // clear-on-read strobes
	logic irq; // unmasked event pending
	logic rst_fn, os_fn; // pin function selects
	logic pulse_q; // reset pulse running
	logic [CW-1:0] pulse_cnt_q; // reset pulse length
	logic pulse_end; // last cycle of the pulse
	logic os_act; // shutdown pin active

	// ======================================================
	// link crossing
	mcir_xfer u_xfer (
		.link_clk(link_clk),
		.lnk_req(lnk_req),
		.lnk_cmd(lnk_cmd),
		.lnk_busy(lnk_busy),
		.lnk_ack(lnk_ack),
		.lnk_rdata(lnk_rdata),
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sys_req(sys_req),
		.sys_cmd(cmd),
		.sys_rdata(rdata)
	);

	// pin synchronisers
	mcir_sync #(
		.WIDTH(3)
	) u_pins (
		.clk(sys_clk),
		.async_in({intrusion_input_i, board_temp_alert_in_n, ext_int_in_n}),
		.sync_out(pins_s)
	);

	assign ext_low = ~pins_s[0]; // R15
	assign board_low = ~pins_s[1]; // R17
	assign intr_high = pins_s[2]; // R19

	// ======================================================
	// access decode
	assign wr_en = sys_req && cmd.wr;
	assign rd_en = sys_req && cmd.rd;
	assign init = wr_en && (cmd.addr == mcir_pkg::OFS_CFG)
		&& cmd.wdata[mcir_pkg::CFG_INIT]; // R11
	assign rd_st1 = rd_en && (cmd.addr == mcir_pkg::OFS_ST1); // R22
	assign rd_st2 = rd_en && (cmd.addr == mcir_pkg::OFS_ST2); // R22

	// read mux, unmapped offsets read zero
	always_comb begin
		unique case (cmd.addr)
			mcir_pkg::OFS_CFG: rdata = cfg_q;
			mcir_pkg::OFS_ST1: rdata = st1_q;
			mcir_pkg::OFS_ST2: rdata = st2_q;
			mcir_pkg::OFS_MSK1: rdata = msk1_q;
			mcir_pkg::OFS_MSK2: rdata = msk2_q;
			mcir_pkg::OFS_FDIV: rdata = fdiv_q;
			mcir_pkg::OFS_TCFG: rdata = tcfg_q;
			default: rdata = 8'h00;
		endcase
	end

	// ======================================================
	// configuration register
	// hold-clear also halts the loop
	assign active = cfg_q[mcir_pkg::CFG_START] && !cfg_q[mcir_pkg::CFG_HOLD_CLR]; // R1 R6
	assign monitor_run = active; // R1

	// software writes, init and self-clearing bits
	always_ff @(posedge sys_clk) begin
		if (sys_rst || init) begin
			cfg_q <= mcir_pkg::RST_CFG; // R12 R11
		end else if (wr_en && (cmd.addr == mcir_pkg::OFS_CFG)) begin
			// init bit never stored, reads zero
			cfg_q <= {1'b0, cmd.wdata[6:0]}; // R11
		end else begin
			// reset bit drops once the pulse is over or unused
			if (pulse_end || (cfg_q[mcir_pkg::CFG_RST_PULSE] && !rst_fn && !pulse_q)) begin
				cfg_q[mcir_pkg::CFG_RST_PULSE] <= 1'b0; // R8
			end
			// intrusion clear drops once the latch reads low
			if (cfg_q[mcir_pkg::CFG_INTR_CLR] && !intr_high) begin
				cfg_q[mcir_pkg::CFG_INTR_CLR] <= 1'b0; // R9
			end
		end
	end

	// ======================================================
	// plain storage registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst || init) begin
			msk1_q <= mcir_pkg::RST_ZERO; // R13 R11
			msk2_q <= mcir_pkg::RST_ZERO; // R11
			fdiv_q <= mcir_pkg::RST_FDIV; // R11
			tcfg_q <= mcir_pkg::RST_TCFG; // R11
		end else if (wr_en) begin
			unique case (cmd.addr)
				mcir_pkg::OFS_MSK1: msk1_q <= cmd.wdata;
				mcir_pkg::OFS_MSK2: msk2_q <= cmd.wdata;
				mcir_pkg::OFS_FDIV: fdiv_q <= cmd.wdata;
				mcir_pkg::OFS_TCFG: tcfg_q <= cmd.wdata;
				default: ;
			endcase
		end
	end

	assign fan_divisor = fdiv_q;
	assign temp_config = tcfg_q;

	// ======================================================
	// temperature event modes, bit 0 hot, bit 1 shutdown
	assign temp_mode = {msk2_q[mcir_pkg::MSK2_OS_MODE],
		msk2_q[mcir_pkg::MSK2_HOT_MODE]}; // R16 R20

	for (genvar i = 0; i < 2; i++) begin : g_temp
		// default mode flags every conversion while hot,
		// one-time flags only the crossings
		always_comb begin
			if (!conv_done || !active) begin
				temp_evt[i] = 1'b0;
			end else if (temp_mode[i]) begin
				temp_evt[i] = (temp_above_limit[i] && !hot_q[i])
					|| (temp_below_hyst[i] && hot_q[i]); // R16 R20
			end else begin
				temp_evt[i] = (temp_above_limit[i] || hot_q[i])
					&& !temp_below_hyst[i]; // R23
			end
		end

		// hysteresis state per sensor
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				hot_q[i] <= 1'b0;
			end else if (conv_done && active) begin
				if (temp_above_limit[i]) begin
					hot_q[i] <= 1'b1;
				end else if (temp_below_hyst[i]) begin
					hot_q[i] <= 1'b0;
				end
			end
		end
	end

	// ======================================================
	// status sets, gated by monitoring
	always_comb begin
		st1_set = 8'h00;
		st2_set = 8'h00;
		if (active) begin
			st1_set[6:0] = conv_done ? volt_out_of_limit : 7'h00; // R14
			st1_set[mcir_pkg::ST1_EXT] = ext_low; // R15
			st2_set[mcir_pkg::ST2_HOT] = temp_evt[0]; // R16
			st2_set[mcir_pkg::ST2_BOARD] = board_low; // R17
			st2_set[mcir_pkg::ST2_FAN0 +: 2] = conv_done ? fan_over_limit : 2'b00; // R18
			st2_set[mcir_pkg::ST2_INTR] = intr_high; // R19
			st2_set[mcir_pkg::ST2_OS] = temp_evt[1]; // R20
		end
	end

	// sticky status, read clears, a set in that cycle wins
	always_ff @(posedge sys_clk) begin
		if (sys_rst || init) begin
			st1_q <= mcir_pkg::RST_ZERO; // R13 R11
			st2_q <= mcir_pkg::RST_ZERO; // R13 R11
		end else begin
			st1_q <= (rd_st1 ? 8'h00 : st1_q) | st1_set; // R22
			st2_q <= (rd_st2 ? 8'h00 : st2_q) | st2_set; // R22
		end
	end

	// ======================================================
	// interrupt pin
	// start bit plays no part, so stopping keeps the line up
	assign irq = |(st1_q & ~msk1_q) | |(st2_q[5:0] & ~msk2_q[5:0]); // R21 R2

	// registered open-drain or open-source drive
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			int_pin_o <= 1'b0;
			int_pin_oe <= 1'b0;
		end else begin
			int_pin_o <= cfg_q[mcir_pkg::CFG_INT_POL]; // R5
			int_pin_oe <= irq && cfg_q[mcir_pkg::CFG_INT_EN]
				&& !cfg_q[mcir_pkg::CFG_HOLD_CLR]; // R24 R4 R6
		end
	end

	// ======================================================
	// reset / shutdown pin
	assign rst_fn = fdiv_q[mcir_pkg::FDIV_RST_EN] && !fdiv_q[mcir_pkg::FDIV_OS_EN]; // R7
	assign os_fn = fdiv_q[mcir_pkg::FDIV_OS_EN] && !fdiv_q[mcir_pkg::FDIV_RST_EN];
	assign pulse_end = pulse_q && (pulse_cnt_q == PULSE_LAST);

	// pulse timer, started by the reset bit
	always_ff @(posedge sys_clk) begin
		if (sys_rst || init) begin
			pulse_q <= 1'b0;
			pulse_cnt_q <= '0;
		end else if (pulse_q) begin
			pulse_q <= !pulse_end; // R7
			pulse_cnt_q <= pulse_cnt_q + 1'b1;
		end else if (cfg_q[mcir_pkg::CFG_RST_PULSE] && rst_fn) begin
			pulse_q <= 1'b1; // R7
			pulse_cnt_q <= '0;
		end
	end

	// comparator mode follows the hot state, one-time follows the flag
	assign os_act = tcfg_q[mcir_pkg::TCFG_ONE_TIME] ? st2_q[mcir_pkg::ST2_OS] : hot_q[1];

	// open-drain low drive
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reset_or_overtemp_pin_oe <= 1'b0;
		end else if (cfg_q[mcir_pkg::CFG_HOLD_CLR]) begin
			reset_or_overtemp_pin_oe <= 1'b0; // R6
		end else begin
			reset_or_overtemp_pin_oe <= (rst_fn && pulse_q) || (os_fn && os_act); // R7
		end
	end

	assign reset_or_overtemp_pin_o = 1'b0;

	// ======================================================
	// intrusion clear and general output
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			intrusion_input_oe <= 1'b0;
			general_output_pin_oe <= 1'b1;
		end else begin
			intrusion_input_oe <= cfg_q[mcir_pkg::CFG_INTR_CLR]; // R9
			general_output_pin_oe <= !cfg_q[mcir_pkg::CFG_GPO]; // R10
		end
	end

	assign intrusion_input_o = 1'b0;
	assign general_output_pin_o = 1'b0;
endmodule
`default_nettype wire

/* File: mcir_pkg.sv */
// package of register map, field positions, reset values and timing of
// the monitor configuration and interrupt register block.
// assumes a 25 MHz core clock and a serial interface that hands over
// decoded byte accesses.
//
// Summary of operation
// (R1) start bit runs monitoring, zero means standby
// (R2) clearing start leaves interrupt pins asserted
// (R3) host programs limits before setting start
// (R4) enable bit gates the interrupt pin
// (R5) polarity bit picks high drive or low drain
// (R6) hold-clear bit idles outputs and halts monitoring; code idles only the interrupt and reset/shutdown pins
// (R7) reset bit gives 10 ms low pulse
// (R8) reset bit self-clears after pulse ends
// (R9) clear bit drains intrusion latch, then self-clears
// (R10) output bit sets general output pin level
// (R11) init bit restores defaults, reads back zero
// (R12) configuration resets to 00001000 binary
// (R13) status and first mask reset to zero
// (R14) status bits 0-6 flag voltage limit events
// (R15) status bit 7 flags low external interrupt
// (R16) hot flag mode chosen by mask bit 6
// (R17) board alert low sets second status bit 1
// (R18) fan counts over limit set bits 2,3
// (R19) intrusion high sets second status bit 4
// (R20) shutdown flag mode chosen by mask bit 7
// (R21) first mask bits block matching status bits
// (R22) status read returns contents then clears
// (R23) default mode re-flags hot after each conversion
// (R24) interrupt when unmasked status, enabled, not held
package mcir_pkg;
	// ======================================================
	// register offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_ST1 = 8'h01;
	localparam logic [7:0] OFS_ST2 = 8'h02;
	localparam logic [7:0] OFS_MSK1 = 8'h03;
	localparam logic [7:0] OFS_MSK2 = 8'h04;
	localparam logic [7:0] OFS_FDIV = 8'h05;
	localparam logic [7:0] OFS_TCFG = 8'h06;
	// ======================================================
	// reset values
	localparam logic [7:0] RST_CFG = 8'h08;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_FDIV = 8'h14;
	localparam logic [7:0] RST_TCFG = 8'h01;
	// ======================================================
	// configuration fields
	localparam int CFG_START = 0;
	localparam int CFG_INT_EN = 1;
	localparam int CFG_INT_POL = 2;
	localparam int CFG_HOLD_CLR = 3;
	localparam int CFG_RST_PULSE = 4;
	localparam int CFG_INTR_CLR = 5;
	localparam int CFG_GPO = 6;
	localparam int CFG_INIT = 7;
	// second status / mask fields, first status external bit
	localparam int ST2_HOT = 0;
	localparam int ST2_BOARD = 1;
	localparam int ST2_FAN0 = 2;
	localparam int ST2_INTR = 4;
	localparam int ST2_OS = 5;
	localparam int MSK2_HOT_MODE = 6;
	localparam int MSK2_OS_MODE = 7;
	localparam int ST1_EXT = 7;
	// fan divisor pin-function fields, temperature config mode field
	localparam int FDIV_OS_EN = 6;
	localparam int FDIV_RST_EN = 7;
	localparam int TCFG_ONE_TIME = 2;
	// ======================================================
	// timing
	localparam int unsigned SYS_CLK_HZ = 25_000_000;
	localparam int unsigned RST_PULSE_MS = 10;
	localparam int unsigned RST_PULSE_CYC = SYS_CLK_HZ / 1000 * RST_PULSE_MS;
	// ======================================================
	// one decoded register access from the serial interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcir_req_t;
endpackage

/* File: mcir_sync.sv */
// two flip-flop level synchroniser for pins entering the core clock.
// assumes inputs are quasi-static levels from outside the domain.
`timescale 1ns/1ps
`default_nettype none
module mcir_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// first stage, read only by the second stage
	logic [WIDTH-1:0] meta_q;

	// two-stage capture
	always_ff @(posedge clk) begin
		meta_q <= async_in;
		sync_out <= meta_q;
	end
endmodule
`default_nettype wire

/* File: mcir_xfer.sv */
// toggle handshake that carries one register access from the link clock
// into the core clock and the read byte back.
// assumes the link side offers a new access only while busy is low.
`timescale 1ns/1ps
`default_nettype none
module mcir_xfer (
	input wire logic link_clk,
	input wire logic lnk_req,
	input wire mcir_pkg::mcir_req_t lnk_cmd,
	output logic lnk_busy,
	output logic lnk_ack,
	output logic [7:0] lnk_rdata,
	input wire logic sys_clk,
	input wire logic sys_rst,
	output logic sys_req,
	output mcir_pkg::mcir_req_t sys_cmd,
	input wire logic [7:0] sys_rdata
);
	// ======================================================
	// link domain
	logic lrst_m_q, lrst_q; // reset brought into link domain
	logic req_tgl_q; // flips once per access
	logic ack_m_q, ack_s_q, ack_seen_q; // returning toggle
	mcir_pkg::mcir_req_t cmd_q; // access held stable while busy
	logic ack_tgl_q; // core side toggle
	logic [7:0] rdata_q; // core side read byte

	// reset synchroniser
	always_ff @(posedge link_clk) begin
		lrst_m_q <= sys_rst;
		lrst_q <= lrst_m_q;
	end

	// ack toggle synchroniser
	always_ff @(posedge link_clk) begin
		ack_m_q <= ack_tgl_q;
		ack_s_q <= ack_m_q;
	end

	// request launch and answer
	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			req_tgl_q <= 1'b0;
			lnk_busy <= 1'b0;
			lnk_ack <= 1'b0;
			lnk_rdata <= 8'h00;
			ack_seen_q <= 1'b0;
			cmd_q <= '0;
		end else begin
			lnk_ack <= 1'b0;
			if (lnk_req && !lnk_busy) begin
				cmd_q <= lnk_cmd;
				req_tgl_q <= ~req_tgl_q;
				lnk_busy <= 1'b1;
			end else if (lnk_busy && (ack_s_q != ack_seen_q)) begin
				ack_seen_q <= ack_s_q;
				lnk_busy <= 1'b0;
				lnk_ack <= 1'b1;
				lnk_rdata <= rdata_q;
			end
		end
	end

	// ======================================================
	// core domain
	logic req_m_q, req_s_q, req_seen_q; // incoming toggle

	// request toggle synchroniser
	always_ff @(posedge sys_clk) begin
		req_m_q <= req_tgl_q;
		req_s_q <= req_m_q;
	end

	assign sys_req = req_s_q ^ req_seen_q; // one core cycle per access
	assign sys_cmd = cmd_q; // stable while toggle in flight

	// answer capture and toggle back
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			req_seen_q <= 1'b0;
			ack_tgl_q <= 1'b0;
			rdata_q <= 8'h00;
		end else if (sys_req) begin
			req_seen_q <= req_s_q;
			ack_tgl_q <= ~ack_tgl_q;
			rdata_q <= sys_rdata;
		end
	end
endmodule
`default_nettype wire

/* File: mcir_checker.sv */
// checker of port-level timing of the monitor register block.
// assumes binding to mcir_top; link signals watched on link_clk.
`timescale 1ns/1ps
`default_nettype none
module mcir_checker #(
	parameter int unsigned RST_PULSE_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic lnk_req,
	input wire logic lnk_busy,
	input wire logic lnk_ack,
	input wire logic [7:0] lnk_rdata,
	input wire logic intrusion_input_i,
	input wire logic intrusion_input_o,
	input wire logic intrusion_input_oe,
	input wire logic reset_or_overtemp_pin_o,
	input wire logic reset_or_overtemp_pin_oe,
	input wire logic general_output_pin_o
);
	// ==========================================
	// length of the current low drive on the reset pin
	int unsigned hi_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !reset_or_overtemp_pin_oe) begin
			hi_q <= 0;
		end else begin
			hi_q <= hi_q + 1;
		end
	end
	// ==========================================
	// pins and handshake
	pins_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!general_output_pin_o && !reset_or_overtemp_pin_o && !intrusion_input_o)
		else $error("open drain pin driven high");
	rst_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(reset_or_overtemp_pin_oe) |-> hi_q == RST_PULSE_CYC)
		else $error("reset pulse length wrong");
	intr_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(intrusion_input_oe && !intrusion_input_i)[*3] |-> ##[0:3] !intrusion_input_oe)
		else $error("intrusion clear not released");
	ack_pulse_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		lnk_ack |=> !lnk_ack)
		else $error("ack longer than one cycle");
	busy_take_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		lnk_req && !lnk_busy |=> lnk_busy)
		else $error("taken access not busy");
	ack_free_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		lnk_ack |-> !lnk_busy)
		else $error("busy during ack");
	ack_bound_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		$rose(lnk_busy) |-> ##[1:20] lnk_ack)
		else $error("access not answered");
	rdata_hold_a: assert property (@(posedge link_clk) disable iff (sys_rst)
		!lnk_ack |-> $stable(lnk_rdata))
		else $error("read byte changed without ack");
endmodule
`default_nettype wire

/* File: mcir_host.sv */
// host model issuing byte accesses on the link side of the block.
// assumes link_clk runs free and the block answers with lnk_ack.
`timescale 1ns/1ps
`default_nettype none
module mcir_host (
	input wire logic link_clk,
	input wire logic lnk_busy,
	input wire logic lnk_ack,
	input wire logic [7:0] lnk_rdata,
	output var logic lnk_req,
	output mcir_pkg::mcir_req_t lnk_cmd
);
	// idle request, command lines parked
	initial begin
		lnk_req = 1'b0;
		lnk_cmd = '0;
	end
	// one access: offer and hold until ack, bounded wait, then release
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 8'h00;
		@(posedge link_clk) #2;
		lnk_cmd = {w, ~w, a, d};
		lnk_req = 1'b1;
		// request and command stand until the ack is seen
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge link_clk) #1;
			if (lnk_ack === 1'b1) begin
				ok = 1'b1;
				q = lnk_rdata;
			end
		end
		// released before the next edge, so no second take
		lnk_req = 1'b0;
		lnk_cmd = '0;
	endtask
endmodule
`default_nettype wire

/* File: mcir_top_tb.sv */
// self-checking bench of the monitor configuration and interrupt block.
// assumes pulse length shortened to 20 core cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
		end \
	end
module mcir_top_tb;
	// ==========================================
	// stimulus and observed signals
	logic sys_clk, sys_rst, link_clk, conv_done, ext_n, board_n, intr_latch;
	logic [6:0] volt, v;
	logic [1:0] fan, tabove, tbelow;
	logic [7:0] m, c;
	logic [31:0] rhi;
	int num_errors = 0;
	int check_count = 0;
	int i, n;
	logic lnk_req, lnk_busy, lnk_ack, intr_pin, intr_o, intr_oe, int_pin_o, int_pin_oe;
	logic rst_o, rst_oe, gpo_o, gpo_oe, mon_run;
	logic [7:0] lnk_rdata;
	mcir_pkg::mcir_req_t lnk_cmd;
	logic [7:0] dflt [0:6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01};
	// intrusion wire: cleared latch while the block drives it
	assign intr_pin = intr_oe ? intr_o : intr_latch;
	always @(posedge sys_clk) if (intr_oe === 1'b1) intr_latch <= 1'b0;
	always @(posedge sys_clk) if (rst_oe === 1'b1) rhi <= rhi + 1;
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	mcir_top #(.RST_PULSE_CYC(20)) mcir_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.link_clk(link_clk), .lnk_req(lnk_req), .lnk_cmd(lnk_cmd), .lnk_busy(lnk_busy),
		.lnk_ack(lnk_ack), .lnk_rdata(lnk_rdata), .conv_done(conv_done),
		.volt_out_of_limit(volt), .fan_over_limit(fan), .temp_above_limit(tabove),
		.temp_below_hyst(tbelow), .ext_int_in_n(ext_n), .board_temp_alert_in_n(board_n),
		.intrusion_input_i(intr_pin), .intrusion_input_o(intr_o),
		.intrusion_input_oe(intr_oe), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
		.reset_or_overtemp_pin_o(rst_o), .reset_or_overtemp_pin_oe(rst_oe),
		.general_output_pin_o(gpo_o), .general_output_pin_oe(gpo_oe),
		.monitor_run(mon_run), .fan_divisor(), .temp_config());
	mcir_host host_i (.link_clk(link_clk), .lnk_busy(lnk_busy), .lnk_ack(lnk_ack),
		.lnk_rdata(lnk_rdata), .lnk_req(lnk_req), .lnk_cmd(lnk_cmd));
	// ==========================================
	// expected interrupt pin state from voltage status
	function automatic logic int_on(logic [7:0] s, logic [7:0] k, logic [7:0] g);
		return (|(s & ~k)) & g[1] & ~g[3];
	endfunction
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic k;
		host_i.access(1'b1, a, d, q, k);
		if (!k) begin
			num_errors++;
			give_verdict();
		end
		settle();
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic k;
		host_i.access(1'b0, a, 8'h00, q, k);
		if (!k) begin
			num_errors++;
			give_verdict();
		end
		`CHK(q, e);
	endtask
	// one conversion result pulse
	task automatic conv(input logic [6:0] vo, input logic [1:0] f, input logic [1:0] ab,
		input logic [1:0] bl);
		@(posedge sys_clk) #2;
		volt = vo;
		fan = f;
		tabove = ab;
		tbelow = bl;
		conv_done = 1'b1;
		@(posedge sys_clk) #2;
		conv_done = 1'b0;
		settle();
	endtask
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(68540));
		{sys_rst, ext_n, board_n} = 3'b111;
		{conv_done, volt, fan, tabove, tbelow, intr_latch} = '0;
		rhi = '0;
		repeat (12) @(posedge sys_clk);
		#2 sys_rst = 1'b0;
		repeat (5) @(posedge link_clk);
		for (i = 0; i < 8; i++) rdc(i[7:0], (i < 7) ? dflt[i] : 8'h00);
		wr(mcir_pkg::OFS_CFG, 8'h02);
		conv(7'h7F, 2'b11, 2'b00, 2'b00);
		rdc(mcir_pkg::OFS_ST1, 8'h00);
		for (i = 0; i < 6; i++) begin
			m = 8'($urandom);
			v = 7'($urandom);
			c = {5'b00000, i[0], i[1] | i[2], 1'b1};
			wr(mcir_pkg::OFS_MSK1, m);
			wr(mcir_pkg::OFS_CFG, c);
			conv(v, 2'b00, 2'b00, 2'b00);
			`CHK(int_pin_oe, int_on({1'b0, v}, m, c));
			`CHK(int_pin_o & int_pin_oe, c[2] & int_on({1'b0, v}, m, c));
			wr(mcir_pkg::OFS_CFG, c & 8'hFE);
			`CHK(int_pin_oe, int_on({1'b0, v}, m, c));
			wr(mcir_pkg::OFS_CFG, c | 8'h08);
			`CHK({int_pin_oe, mon_run}, 2'b00);
			rdc(mcir_pkg::OFS_ST1, {1'b0, v});
			rdc(mcir_pkg::OFS_ST1, 8'h00);
		end
		wr(mcir_pkg::OFS_CFG, 8'h01);
		@(posedge sys_clk) #2;
		{ext_n, board_n, intr_latch} = 3'b001;
		conv(7'h00, 2'b11, 2'b00, 2'b00);
		{ext_n, board_n} = 2'b11;
		settle();
		rdc(mcir_pkg::OFS_ST1, 8'h80);
		rdc(mcir_pkg::OFS_ST2, 8'h1E);
		wr(mcir_pkg::OFS_CFG, 8'h21);
		`CHK(intr_latch, 1'b0);
		rdc(mcir_pkg::OFS_CFG, 8'h01);
		rdc(mcir_pkg::OFS_ST2, 8'h10);
		// temperature flags in default and one-time modes
		conv(7'h00, 2'b00, 2'b11, 2'b00);
		rdc(mcir_pkg::OFS_ST2, 8'h21);
		conv(7'h00, 2'b00, 2'b00, 2'b00);
		rdc(mcir_pkg::OFS_ST2, 8'h21);
		conv(7'h00, 2'b00, 2'b00, 2'b11);
		rdc(mcir_pkg::OFS_ST2, 8'h00);
		wr(mcir_pkg::OFS_MSK2, 8'hC0);
		for (i = 0; i < 2; i++) begin
			conv(7'h00, 2'b00, 2'b11, 2'b00);
			rdc(mcir_pkg::OFS_ST2, i ? 8'h00 : 8'h21);
		end
		// reset pulse without and with the pin function
		wr(mcir_pkg::OFS_CFG, 8'h11);
		rdc(mcir_pkg::OFS_CFG, 8'h01);
		`CHK(rhi, 32'd0);
		wr(mcir_pkg::OFS_FDIV, 8'h94);
		wr(mcir_pkg::OFS_CFG, 8'h11);
		for (n = 0; n < 200 && (rst_oe === 1'b1 || rhi == 0); n++) @(posedge sys_clk);
		`CHK(rhi, 32'd20);
		rdc(mcir_pkg::OFS_CFG, 8'h01);
		wr(mcir_pkg::OFS_CFG, 8'h41);
		`CHK(gpo_oe, 1'b0);
		wr(mcir_pkg::OFS_MSK1, 8'hFF);
		wr(mcir_pkg::OFS_CFG, 8'h80);
		for (i = 0; i < 7; i++) rdc(i[7:0], dflt[i]);
		`CHK(gpo_oe, 1'b1);
		give_verdict();
	end
endmodule
bind mcir_top mcir_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) mcir_checker_i (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .lnk_req(lnk_req),
	.lnk_busy(lnk_busy), .lnk_ack(lnk_ack), .lnk_rdata(lnk_rdata),
	.intrusion_input_i(intrusion_input_i), .intrusion_input_o(intrusion_input_o),
	.intrusion_input_oe(intrusion_input_oe), .reset_or_overtemp_pin_o(reset_or_overtemp_pin_o),
	.reset_or_overtemp_pin_oe(reset_or_overtemp_pin_oe),
	.general_output_pin_o(general_output_pin_o));
`default_nettype wire
